/* File: design/prs_defines.vh */
`ifndef PRS_DEFINES_VH
`define PRS_DEFINES_VH

// ==========================================================
// apb register byte offsets
`define PRS_OFS_CTRL 8'h00
`define PRS_OFS_LOWSP 8'h04
`define PRS_OFS_RATED 8'h08
`define PRS_OFS_STATE 8'h0c
`define PRS_OFS_MEAS 8'h10
`define PRS_OFS_IRQ_STAT 8'h14
`define PRS_OFS_IRQ_MASK 8'h18

// ==========================================================
// control register fields
`define PRS_CTRL_LOW_SEL 0
`define PRS_CTRL_SER_START 1
`define PRS_CTRL_SER_STOP 2

// ==========================================================
// low-speed setpoint, in tenths of a percent of rated speed
`define PRS_LOWSP_MIN 10'h0fa
`define PRS_LOWSP_MAX 10'h3e8
`define PRS_LOWSP_RST 10'h3e8
`define PRS_PERMILLE_FULL 10'h3e8

// ==========================================================
// thresholds: normal at 4/5 of target, rotation off at 60 rpm
`define PRS_NORM_NUM 3'h4
`define PRS_NORM_DEN 3'h5
`define PRS_STOP_RPM 16'h003c

// ==========================================================
// displayed operation state codes
`define PRS_OP_STOP 2'h0
`define PRS_OP_ACC 2'h1
`define PRS_OP_NORMAL 2'h2
`define PRS_OP_BRAKE 2'h3

// ==========================================================
// interrupt event bit positions
`define PRS_EV_START 0
`define PRS_EV_NORMAL 1
`define PRS_EV_BRAKE 2
`define PRS_EV_STOPPED 3
`define PRS_EV_REJECT 4
`define PRS_EV_W 5

`endif

/* File: design/prs_sync.v */
`timescale 1ns/1ns
`default_nettype none

// ==========================================================
// two-stage synchroniser for asynchronous pin levels
module prs_sync #(
    parameter W = 1
) (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // pins in, synchronised levels out
    input wire [W-1:0] d,
    output reg [W-1:0] q
);

    reg [W-1:0] meta;

    // first stage feeds only the second stage
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta <= {W{1'b0}};
            q <= {W{1'b0}};
        end
        else
        begin
            meta <= d;
            q <= meta;
        end
    end

endmodule

`default_nettype wire

/* File: design/prs_sequencer.v */
`timescale 1ns/1ns
`default_nettype none
`include "prs_defines.vh"

module prs_sequencer #(
    parameter [15:0] RATED_RPM_RST = 16'h4e20
) (
    // apb slave
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // front panel pins
    input wire start_sw,
    input wire stop_sw,
    input wire remote_sw,
    // remote-control connector inputs
    input wire rem_start,
    input wire rem_stop,
    input wire rem_low_speed,
    // measured rotor speed from the speed logic, rpm
    input wire [15:0] meas_speed,
    // indications, shared by lamps and connector outputs
    output reg rotation_ind,
    output reg accel_state_indication,
    output reg normal_ind,
    output reg brake_ind,
    output reg remote_ind,
    output reg [1:0] op_state,
    // drive requests, fixed ramp rates inside the drive
    output reg accel_cmd,
    output reg decel_cmd,
    // interrupt
    output reg irq
);

    // ==========================================================
    // states, one-hot
    localparam [4:0] S_STOP = 5'h01;
    localparam [4:0] S_ACC = 5'h02;
    localparam [4:0] S_NORM = 5'h04;
    localparam [4:0] S_SLOW = 5'h08;
    localparam [4:0] S_BRAKE = 5'h10;

    reg [4:0] state;
    reg [4:0] next_state;

    // ==========================================================
    // pin synchronisation and edge detection
    wire [5:0] pins_s;
    reg [4:0] pins_d;

    prs_sync #(
        .W(6)
    ) u_sync (
        .clk(pclk),
        .rst_n(presetn),
        .d({rem_low_speed, remote_sw, rem_stop, rem_start, stop_sw,
            start_sw}),
        .q(pins_s)
    );

    // edges taken from the synchronised copies only
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pins_d <= 5'h00;
        else
            pins_d <= pins_s[4:0];
    end

    wire remote_mode = pins_s[4];
    wire start_sw_ev = pins_s[0] & ~pins_d[0];
    wire stop_sw_ev = pins_s[1] & ~pins_d[1];
    wire rem_start_ev = pins_s[2] & ~pins_d[2];
    wire rem_stop_ev = pins_s[3] & ~pins_d[3];

    // ==========================================================
    // registers
    reg low_sel;
    reg [9:0] low_sp;
    reg [15:0] rated_rpm;
    reg [`PRS_EV_W-1:0] irq_stat;
    reg [`PRS_EV_W-1:0] irq_mask;
    reg ser_start;
    reg ser_stop;

    wire setup = psel & ~penable;
    wire access = psel & penable;
    wire wr = access & pwrite;
    wire rd = access & ~pwrite;
    wire mapped = (paddr == `PRS_OFS_CTRL) | (paddr == `PRS_OFS_LOWSP) |
        (paddr == `PRS_OFS_RATED) | (paddr == `PRS_OFS_STATE) |
        (paddr == `PRS_OFS_MEAS) | (paddr == `PRS_OFS_IRQ_STAT) |
        (paddr == `PRS_OFS_IRQ_MASK);
    wire [9:0] sp_wr = pwdata[9:0];
    wire sp_ok = (pwdata[31:10] == 22'h000000) &
        (sp_wr >= `PRS_LOWSP_MIN) & (sp_wr <= `PRS_LOWSP_MAX);
    wire sp_write = wr & (paddr == `PRS_OFS_LOWSP);
    wire stat_rd = rd & (paddr == `PRS_OFS_IRQ_STAT);

    // zero wait states; unmapped addresses error out
    assign pready = 1'b1;
    assign pslverr = access & ~mapped;

    // ==========================================================
    // command arbitration by mode
    // serial commands count as remote; panel switches ignored there
    wire cmd_start = remote_mode ? (rem_start_ev | ser_start) :
        start_sw_ev;
    wire cmd_stop = remote_mode ? (rem_stop_ev | ser_stop) :
        stop_sw_ev;

    // mode source by location, taken in any state
    wire low_mode = remote_mode ? pins_s[5] : low_sel;

    // ==========================================================
    // target and threshold compare, scaled to avoid a divider
    // both sides carry a factor of 1000 so permille needs no division
    wire [9:0] tgt_pm = low_mode ? low_sp : `PRS_PERMILLE_FULL;
    wire [27:0] tgt_sc = {12'h000, rated_rpm} * {18'h00000, tgt_pm};
    wire [27:0] meas_sc = {12'h000, meas_speed} *
        {18'h00000, `PRS_PERMILLE_FULL};
    // two spare bits: top speed times five overflows 28 bits
    wire [29:0] meas_x5 = {2'b00, meas_sc} * {27'h0000000, `PRS_NORM_DEN};
    wire [29:0] tgt_x4 = {2'b00, tgt_sc} * {27'h0000000, `PRS_NORM_NUM};
    wire at_norm = meas_x5 >= tgt_x4;
    wire below_tgt = meas_sc < tgt_sc;
    wire above_tgt = meas_sc > tgt_sc;
    wire at_rest = meas_speed <= `PRS_STOP_RPM;

    // ==========================================================
    // run-state machine
    always @*
    begin
        next_state = state;
        case (state)
            S_STOP:
                if (cmd_start)
                    next_state = S_ACC;
            S_ACC:
                if (cmd_stop)
                    next_state = S_BRAKE;
                else if (at_norm)
                    next_state = S_NORM;
            S_NORM:
                if (cmd_stop)
                    next_state = S_BRAKE;
                else if (!at_norm)
                    next_state = S_ACC;
                else if (above_tgt)
                    next_state = S_SLOW;
            S_SLOW:
                if (cmd_stop)
                    next_state = S_BRAKE;
                else if (!above_tgt)
                    next_state = S_NORM;
            S_BRAKE:
                if (at_rest)
                    next_state = S_STOP;
            default:
                next_state = S_STOP;
        endcase
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state <= S_STOP;
        else
            state <= next_state;
    end

    // ==========================================================
    // indications registered from the next state; remote_ind from the synchronised remote pin
    // brake and rotation fall on the same edge at the stop
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rotation_ind <= 1'b0;
            accel_state_indication <= 1'b0;
            normal_ind <= 1'b0;
            brake_ind <= 1'b0;
            remote_ind <= 1'b0;
            op_state <= `PRS_OP_STOP;
            accel_cmd <= 1'b0;
            decel_cmd <= 1'b0;
        end
        else
        begin
            rotation_ind <= ~next_state[0];
            accel_state_indication <= next_state[1];
            normal_ind <= next_state[2];
            brake_ind <= next_state[3] | next_state[4];
            remote_ind <= remote_mode;
            if (next_state[1])
                op_state <= `PRS_OP_ACC;
            else if (next_state[2])
                op_state <= `PRS_OP_NORMAL;
            else if (next_state[3] | next_state[4])
                op_state <= `PRS_OP_BRAKE;
            else
                op_state <= `PRS_OP_STOP;
            // one ramp rate in the drive serves start, stop and retarget
            accel_cmd <= (next_state[1] | next_state[2]) &
                below_tgt;
            decel_cmd <= next_state[4] | next_state[3] |
                (next_state[2] & above_tgt);
        end
    end

    // ==========================================================
    // register writes; serial start and stop are one-cycle pulses
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            low_sel <= 1'b0;
            low_sp <= `PRS_LOWSP_RST;
            rated_rpm <= RATED_RPM_RST;
            irq_mask <= {`PRS_EV_W{1'b0}};
            ser_start <= 1'b0;
            ser_stop <= 1'b0;
        end
        else
        begin
            ser_start <= wr & (paddr == `PRS_OFS_CTRL) &
                pwdata[`PRS_CTRL_SER_START];
            ser_stop <= wr & (paddr == `PRS_OFS_CTRL) &
                pwdata[`PRS_CTRL_SER_STOP];
            if (wr & (paddr == `PRS_OFS_CTRL))
                low_sel <= pwdata[`PRS_CTRL_LOW_SEL];
            // out-of-range setpoints leave the old value in place
            if (sp_write & sp_ok)
                low_sp <= sp_wr;
            if (wr & (paddr == `PRS_OFS_RATED))
                rated_rpm <= pwdata[15:0];
            if (wr & (paddr == `PRS_OFS_IRQ_MASK))
                irq_mask <= pwdata[`PRS_EV_W-1:0];
        end
    end

    // ==========================================================
    // sticky events; a new event wins over the read clear
    wire [`PRS_EV_W-1:0] ev;
    assign ev[`PRS_EV_START] = state[0] & next_state[1];
    assign ev[`PRS_EV_NORMAL] = ~state[2] & next_state[2];
    assign ev[`PRS_EV_BRAKE] = ~state[4] & next_state[4];
    assign ev[`PRS_EV_STOPPED] = state[4] & next_state[0];
    assign ev[`PRS_EV_REJECT] = sp_write & ~sp_ok;

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_stat <= {`PRS_EV_W{1'b0}};
        else if (stat_rd)
            irq_stat <= ev;
        else
            irq_stat <= irq_stat | ev;
    end

    // level interrupt, one cycle behind the status bits
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq <= 1'b0;
        else
            irq <= |(irq_stat & irq_mask);
    end

    // ==========================================================
    // read data captured in the setup phase
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h00000000;
        else if (setup & ~pwrite)
        begin
            case (paddr)
                `PRS_OFS_CTRL:
                    prdata <= {31'h00000000, low_sel};
                `PRS_OFS_LOWSP:
                    prdata <= {22'h000000, low_sp};
                `PRS_OFS_RATED:
                    prdata <= {16'h0000, rated_rpm};
                `PRS_OFS_STATE:
                    prdata <= {19'h00000, low_mode, remote_mode, op_state,
                        state, brake_ind, normal_ind,
                        accel_state_indication, rotation_ind};
                `PRS_OFS_MEAS:
                    prdata <= {16'h0000, meas_speed};
                `PRS_OFS_IRQ_STAT:
                    prdata <= {27'h0000000, irq_stat | ev}; // setup events too
                `PRS_OFS_IRQ_MASK:
                    prdata <= {27'h0000000, irq_mask};
                default:
                    prdata <= 32'h00000000;
            endcase
        end
    end

endmodule

`default_nettype wire

/* File: tb/prs_monitor.sv */
`timescale 1ns/1ns
`default_nettype none

// ==========================================================
// port checker for the run-state sequencer
module prs_monitor (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // measured speed
    input wire logic [15:0] meas_speed,
    // indications and drive requests
    input wire logic rotation_ind,
    input wire logic accel_state_indication,
    input wire logic normal_ind,
    input wire logic brake_ind,
    input wire logic [1:0] op_state,
    input wire logic accel_cmd,
    input wire logic decel_cmd
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // a run begins: stop code, then accel code one edge later
    sequence s_launch;
        op_state == 2'h0 ##1 op_state == 2'h1;
    endsequence

    // braking rotor has reached the stop threshold
    sequence s_settle;
        brake_ind && meas_speed <= 16'h003c;
    endsequence

    chk_launch_lamps: assert property (
        s_launch |-> rotation_ind && accel_state_indication)
        else $error("start without lamps");
    chk_settle_drop: assert property (
        s_settle |=> !rotation_ind && !brake_ind && op_state == 2'h0)
        else $error("no stop at low speed");
    chk_rot_floor: assert property (
        $fell(rotation_ind) |-> $past(meas_speed) <= 16'h003c)
        else $error("rotation off too fast");
    chk_rot_hold: assert property (
        rotation_ind && meas_speed > 16'h003c |=> rotation_ind)
        else $error("rotation dropped above floor");
    chk_drop_pair: assert property (
        $fell(brake_ind) && op_state == 2'h0 |-> $fell(rotation_ind))
        else $error("brake and rotation apart");
    chk_brake_shown: assert property (
        op_state == 2'h3 |-> brake_ind && !normal_ind && decel_cmd)
        else $error("brake code mismatch");
    chk_normal_shown: assert property (
        op_state == 2'h2 |-> normal_ind && !accel_state_indication &&
        !brake_ind) else $error("normal code mismatch");
    chk_stop_dark: assert property (
        op_state == 2'h0 |-> !rotation_ind && !normal_ind && !accel_cmd)
        else $error("stop code not dark");
endmodule

`default_nettype wire

/* File: tb/prs_host_model.sv */
`timescale 1ns/1ns
`default_nettype none

// ==========================================================
// host equipment on the remote-control connector
module prs_host_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // bench requests
    input wire logic req_start,
    input wire logic req_stop,
    input wire logic low_req,
    // connector pins
    output logic rem_start,
    output logic rem_stop,
    output logic rem_low_speed
);
    logic [3:0] hold;

    // command levels held well past the device's sync depth
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rem_start <= 1'b0;
            rem_stop <= 1'b0;
            rem_low_speed <= 1'b0;
            hold <= 4'h0;
        end
        else
        begin
            rem_low_speed <= low_req;
            if (req_start || req_stop)
            begin
                rem_start <= req_start;
                rem_stop <= req_stop;
                hold <= 4'h6;
            end
            else if (hold != 4'h0)
                hold <= hold - 4'h1;
            else
            begin
                rem_start <= 1'b0;
                rem_stop <= 1'b0;
            end
        end
    end
endmodule

`default_nettype wire

/* File: tb/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none

// ==========================================================
// bench top
module tb_top;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, start_sw = 1'b0, stop_sw = 1'b0, remote_sw = 1'b0;
    logic req_start = 1'b0, req_stop = 1'b0, low_req = 1'b0, err;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, rd;
    logic [15:0] meas_speed = 16'h0000;
    wire [31:0] prdata;
    wire [1:0] op_state;
    wire pready, pslverr, rem_start, rem_stop, rem_low_speed, rotation_ind;
    wire accel_state_indication, normal_ind, brake_ind, remote_ind;
    wire accel_cmd, decel_cmd, irq;
    int n_errors = 0, check_count = 0, i;
    logic [31:0] sp_in [5] = '{32'h0f9, 32'h3e9, 32'h103e8, 32'h0fa, 32'h3e8};
    logic [31:0] sp_out [5] = '{32'h3e8, 32'h3e8, 32'h3e8, 32'h0fa, 32'h3e8};

    always #25 pclk = ~pclk;

    prs_sequencer i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .start_sw, .stop_sw, .remote_sw,
        .rem_start, .rem_stop, .rem_low_speed, .meas_speed, .rotation_ind,
        .accel_state_indication, .normal_ind, .brake_ind, .remote_ind,
        .op_state, .accel_cmd, .decel_cmd, .irq);
    prs_host_model i_host (.pclk, .presetn, .req_start, .req_stop, .low_req,
        .rem_start, .rem_stop, .rem_low_speed);

    // ==========================================================
    // tasks
    task end_sim;
    begin
        $display("counts: %0d checks, %0d mismatches", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    end
    endtask

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    begin
        check_count++;
        if (g !== e)
        begin
            n_errors++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    end
    endtask

    // one apb transfer; the idle edge first keeps back-to-back calls clean
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
    begin
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1)
            chk("pready", 32'h1, pready);
        if (pready !== 1'b1)
            end_sim;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    end
    endtask

    task rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    begin
        apb(1'b0, a, 32'h0);
        chk(nm, e, rd);
    end
    endtask

    function logic sig(input int s);
        case (s)
            0: sig = rotation_ind;
            1: sig = normal_ind;
            default: sig = brake_ind;
        endcase
    endfunction

    // bounded wait for an indication level
    task wait_on(input int s, input logic v);
        int k;
    begin
        k = 0;
        while (sig(s) !== v && k < 40)
        begin
            @(posedge pclk);
            k++;
        end
        chk("wait level", v, sig(s));
        if (sig(s) !== v)
            end_sim;
    end
    endtask

    // pin held for several edges so the synchroniser sees it
    task pin(input int s);
    begin
        @(posedge pclk);
        case (s)
            0: start_sw <= 1'b1;
            1: stop_sw <= 1'b1;
            2: req_start <= 1'b1;
            default: req_stop <= 1'b1;
        endcase
        repeat (6) @(posedge pclk);
        {start_sw, stop_sw, req_start, req_stop} <= 4'h0;
    end
    endtask

    // ==========================================================
    // main sequence
    initial
    begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rchk("ctrl", 8'h00, 32'h0);
        rchk("lowsp", 8'h04, 32'h3e8);
        rchk("rated", 8'h08, 32'h4e20);
        rchk("state", 8'h0c, 32'h10);
        rchk("mask", 8'h18, 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        chk("slverr", 32'h1, err);
        chk("unmapped", 32'h0, rd);
        for (i = 0; i < 5; i++)
        begin
            apb(1'b1, 8'h04, sp_in[i]);
            rchk("lowsp", 8'h04, sp_out[i]);
        end
        rchk("irq_stat", 8'h14, 32'h10);
        // low mode while stopped; serial bits count for nothing locally
        apb(1'b1, 8'h00, 32'h7);
        rchk("ctrl", 8'h00, 32'h1);
        rchk("state", 8'h0c, 32'h1010);
        apb(1'b1, 8'h00, 32'h0);
        $display("test reset and setpoint done");
        pin(2);
        repeat (8) @(posedge pclk);
        chk("rot", 32'h0, rotation_ind);
        meas_speed <= 16'h3e7f;
        pin(0);
        wait_on(0, 1'b1);
        chk("acc", 32'h1, accel_state_indication);
        chk("accel_cmd", 32'h1, accel_cmd);
        chk("irq", 32'h0, irq);
        rchk("state", 8'h0c, 32'h223);
        chk("norm", 32'h0, normal_ind);
        meas_speed <= 16'h3e80;
        wait_on(1, 1'b1);
        chk("op", 32'h2, op_state);
        meas_speed <= 16'h4e20;
        pin(1);
        wait_on(2, 1'b1);
        chk("op", 32'h3, op_state);
        meas_speed <= 16'h003d;
        repeat (6) @(posedge pclk);
        chk("rot", 32'h1, rotation_ind);
        meas_speed <= 16'h003c;
        wait_on(0, 1'b0);
        chk("op", 32'h0, op_state);
        apb(1'b1, 8'h18, 32'h1f);
        repeat (2) @(posedge pclk);
        chk("irq", 32'h1, irq);
        rchk("irq_stat", 8'h14, 32'h0f);
        repeat (2) @(posedge pclk);
        chk("irq", 32'h0, irq);
        $display("test local run done");
        remote_sw <= 1'b1;
        low_req <= 1'b1;
        apb(1'b1, 8'h04, 32'h1f4);
        meas_speed <= 16'h1f3f;
        pin(0);
        repeat (8) @(posedge pclk);
        chk("remote_ind", 32'h1, remote_ind);
        chk("rot", 32'h0, rotation_ind);
        pin(2);
        wait_on(0, 1'b1);
        chk("acc", 32'h1, accel_state_indication);
        chk("norm", 32'h0, normal_ind);
        meas_speed <= 16'h1f40;
        wait_on(1, 1'b1);
        chk("acc", 32'h0, accel_state_indication);
        meas_speed <= 16'h2328;
        apb(1'b1, 8'h04, 32'h0fa);
        wait_on(2, 1'b1);
        chk("decel", 32'h1, decel_cmd);
        meas_speed <= 16'h1388;
        wait_on(2, 1'b0);
        chk("norm", 32'h1, normal_ind);
        low_req <= 1'b0;
        wait_on(1, 1'b0);
        chk("acc", 32'h1, accel_state_indication);
        pin(3);
        wait_on(2, 1'b1);
        chk("op", 32'h3, op_state);
        meas_speed <= 16'h0000;
        wait_on(0, 1'b0);
        chk("brake", 32'h0, brake_ind);
        $display("test remote run done");
        // serial start and stop act in remote mode
        apb(1'b1, 8'h00, 32'h2);
        wait_on(0, 1'b1);
        chk("acc", 32'h1, accel_state_indication);
        meas_speed <= 16'h0064;
        apb(1'b1, 8'h00, 32'h4);
        wait_on(2, 1'b1);
        meas_speed <= 16'h0000;
        wait_on(0, 1'b0);
        chk("op", 32'h0, op_state);
        $display("test serial run done");
        end_sim;
    end
endmodule

bind prs_sequencer prs_monitor i_mon (.pclk, .presetn, .meas_speed,
    .rotation_ind, .accel_state_indication, .normal_ind, .brake_ind,
    .op_state, .accel_cmd, .decel_cmd);

`default_nettype wire
